// ==== shared/cfq_pkg.sv ====
package cfq_pkg;
    // ******************************************************************
    // timing and configuration constants
    // ******************************************************************
    localparam int CLK_PERIOD_NS     = 40;        // core clock period
    localparam int DEF_DEPTH         = 16;        // default queue depth
    localparam int MIN_DEPTH         = 16;        // smallest supported depth
    localparam int MAX_DEPTH         = 4194304;   // largest supported depth
    localparam longint MAX_BITS      = 150000000; // total storage limit
    localparam int DEF_WR_WIDTH      = 32;        // default write width
    localparam int DEF_RD_WIDTH      = 32;        // default custom read width
    localparam int DEF_PRECISION     = 4;         // default fill fraction bits
    localparam int DEF_RST_STAGES    = 1;         // default reset latency
    localparam int DISABLE_CYCLES    = 20;        // post reset dead window
    localparam int NORST_WAIT_CYCLES = 8;         // wait without reset port
    localparam int RST_HOLD_MIN      = 3;         // least reset hold
    localparam int RST_HOLD_PREF     = 5;         // preferred reset hold
    localparam int POST_RST_WAIT     = 30;        // no-access zone after reset
    localparam int CTRL_ADDR_W       = 4;         // controller register address width
    // controller register offsets (word index)
    localparam logic [3:0] REG_CTRL   = 4'h0;     // bit1 soft reset
    localparam logic [3:0] REG_WDATA  = 4'h1;     // write: push word
    localparam logic [3:0] REG_RDATA  = 4'h2;     // read: last popped word
    localparam logic [3:0] REG_STATUS = 4'h3;     // flags
    localparam logic [3:0] REG_COUNT  = 4'h4;     // word count
    localparam logic [3:0] REG_POP    = 4'h5;     // write: request pop
    localparam int CTRL_SRST_BIT      = 1;        // soft reset request bit
    // status field positions
    localparam int ST_EMPTY  = 0;
    localparam int ST_FULL   = 1;
    localparam int ST_NEMPTY = 2;
    localparam int ST_NFULL  = 3;
    localparam int ST_BUSY   = 4;
    localparam int ST_RVALID = 5;
endpackage

// ==== shared/cfq_if.sv ====
`timescale 1ns/10ps
interface cfq_if #(
    parameter int WR_W = 32,
    parameter int RD_W = 32,
    parameter int CNT_W = 5,
    parameter int PREC = 4
);
    logic             rst_req;     // reset request from controller, high active
    logic             enable;      // optional clock enable
    logic             write_strobe;
    logic [WR_W-1:0]  write_data;
    logic             read_strobe;
    logic [RD_W-1:0]  read_data;
    logic             read_valid;
    logic             full;
    logic             empty;
    logic             near_empty_flag;
    logic             near_full_flag;
    logic [CNT_W-1:0] word_count;
    logic [PREC-1:0]  fill_fraction;
    logic             rst_busy;    // queue still in reset window
    modport dev (input rst_req, enable, write_strobe, write_data, read_strobe,
                 output read_data, read_valid, full, empty, near_empty_flag,
                 near_full_flag, word_count, fill_fraction, rst_busy);
    modport ctl (output rst_req, enable, write_strobe, write_data, read_strobe,
                 input read_data, read_valid, full, empty, near_empty_flag,
                 near_full_flag, word_count, fill_fraction, rst_busy);
endinterface

// ==== rtl/cfq_rst_pipe.sv ====
`timescale 1ns/10ps
module cfq_rst_pipe #(
    parameter int STAGES = 1
) (
    input  wire logic CORE_CLK,
    input  wire logic ARST_N,
    input  wire logic req_in,
    output logic      req_out
);
    // ******************************************************************
    // reset latency pipeline
    // ******************************************************************
    typedef struct packed {
        logic [STAGES-1:0] sh; // delay stages
    } cfq_rp_state_type;
    cfq_rp_state_type st_r;
    cfq_rp_state_type st_nxt;

    initial begin
        if (STAGES < 1) $error("reset latency must be at least one");
    end

    // shift the request through the stages, one per clock
    always_comb begin
        st_nxt = st_r;
        // one bit wider than the pipe; the cast drops the oldest stage on purpose,
        // and a single stage needs no reversed part-select
        st_nxt.sh = STAGES'({st_r.sh, req_in});
    end

    // async reset counts as an active request
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_r <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign req_out = st_r.sh[STAGES-1];
endmodule

// ==== rtl/cfq_queue.sv ====
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/10ps
module cfq_queue #(
    parameter int DEPTH      = cfq_pkg::DEF_DEPTH,
    parameter int WR_W       = cfq_pkg::DEF_WR_WIDTH,
    parameter int RD_W       = cfq_pkg::DEF_RD_WIDTH,
    parameter int PREC       = cfq_pkg::DEF_PRECISION,
    parameter int RST_STAGES = cfq_pkg::DEF_RST_STAGES,
    parameter bit LOOK_AHEAD = 1'b0,
    parameter bit OUT_REG    = 1'b0,
    parameter bit HAS_ENABLE = 1'b0,
    parameter int CNT_W      = $clog2(DEPTH) + 1
) (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    cfq_if.dev       Q
);
    // ******************************************************************
    // geometry: storage is held in units of the narrower width
    // ******************************************************************
    localparam int UNIT_W  = (WR_W < RD_W) ? WR_W : RD_W;
    localparam int WR_K    = WR_W / UNIT_W;              // units per write
    localparam int RD_K    = RD_W / UNIT_W;              // units per read
    localparam int KMAX    = (WR_K > RD_K) ? WR_K : RD_K;
    localparam int UNITS   = DEPTH * WR_K;               // depth counts write words
    localparam int PTR_W   = $clog2(UNITS);
    localparam int UCNT_W  = PTR_W + 1;
    localparam int TMR_W   = $clog2(cfq_pkg::DISABLE_CYCLES + 1);

    // elaboration checks
    initial begin
        if (DEPTH < cfq_pkg::MIN_DEPTH || DEPTH > cfq_pkg::MAX_DEPTH)
            $error("depth out of range");
        if ((DEPTH & (DEPTH - 1)) != 0)
            $error("depth must be a power of two");
        if (!(KMAX == 1 || KMAX == 2 || KMAX == 4 || KMAX == 8) ||
            (WR_W % UNIT_W) != 0 || (RD_W % UNIT_W) != 0)
            $error("write to read width ratio not supported");
        if (longint'(DEPTH) * longint'(WR_W) > cfq_pkg::MAX_BITS)
            $error("total storage exceeds limit");
        if (PREC < 1 || PREC > PTR_W) $error("precision out of range");
        if (CNT_W < UCNT_W - $clog2(WR_K)) $error("count width too small");
    end

    // storage array, declared here because it holds many words
    logic [UNIT_W-1:0] mem [UNITS];

    // ******************************************************************
    // state
    // ******************************************************************
    typedef struct packed {
        logic [PTR_W-1:0]  wptr;    // next free unit
        logic [PTR_W-1:0]  rptr;    // oldest unit
        logic [UCNT_W-1:0] ucnt;    // units stored
        logic [TMR_W-1:0]  dead;    // post reset disable timer
        logic [RD_W-1:0]   dout;    // read data stage
        logic              dvalid;  // read data stage valid
        logic [RD_W-1:0]   oreg;    // optional output register
        logic              ovalid;
        logic              full;
        logic              empty;
        logic              nempty;
        logic              nfull;
        logic [CNT_W-1:0]  wcnt;
        logic [PREC-1:0]   frac;
    } cfq_q_state_type;
    cfq_q_state_type st_r;
    cfq_q_state_type st_nxt;

    logic             srst;      // delayed reset request
    logic [RD_W-1:0]  rd_word;   // word at read pointer
    logic [UCNT_W-1:0] ucnt_new;

    cfq_rst_pipe #(.STAGES(RST_STAGES)) u_rst (
        .CORE_CLK (CORE_CLK),
        .ARST_N   (ARST_N),
        .req_in   (Q.rst_req),
        .req_out  (srst)
    );

    // gather the read word from consecutive units, oldest in the low bits
    always_comb begin
        rd_word = '0;
        for (int i = 0; i < RD_K; i++) begin
            rd_word[i*UNIT_W +: UNIT_W] = mem[PTR_W'(st_r.rptr + PTR_W'(i))];
        end
    end

    // ******************************************************************
    // next state
    // ******************************************************************
    always_comb begin
        logic en;
        logic can_wr;
        logic can_rd;
        logic pop;
        en     = 1'b0;
        can_wr = 1'b0;
        can_rd = 1'b0;
        pop    = 1'b0;
        st_nxt = st_r;
        ucnt_new = st_r.ucnt;
        // optional enable gates writes and pops
        en = (HAS_ENABLE ? Q.enable : 1'b1) && (st_r.dead == '0);
        // room and data measured in whole words
        can_wr = en && Q.write_strobe && (st_r.ucnt <= UCNT_W'(UNITS - WR_K));
        can_rd = st_r.ucnt >= UCNT_W'(RD_K);
        if (LOOK_AHEAD) begin
            // head word falls through; a strobe consumes it
            pop = en && can_rd && (!st_r.dvalid || Q.read_strobe);
        end else begin
            pop = en && can_rd && Q.read_strobe;
        end
        if (st_r.dead != '0) st_nxt.dead = st_r.dead - TMR_W'(1);
        if (can_wr) begin
            st_nxt.wptr = PTR_W'(st_r.wptr + PTR_W'(WR_K));
            ucnt_new = ucnt_new + UCNT_W'(WR_K);
        end
        if (pop) begin
            st_nxt.rptr = PTR_W'(st_r.rptr + PTR_W'(RD_K));
            ucnt_new = ucnt_new - UCNT_W'(RD_K);
            st_nxt.dout   = rd_word;
            st_nxt.dvalid = 1'b1;
        end else if (LOOK_AHEAD ? (en && Q.read_strobe) : 1'b1) begin
            st_nxt.dvalid = 1'b0;
        end
        st_nxt.ucnt   = ucnt_new;
        st_nxt.full   = ucnt_new > UCNT_W'(UNITS - WR_K);
        st_nxt.empty  = ucnt_new < UCNT_W'(RD_K);
        st_nxt.nempty = ucnt_new < UCNT_W'(2 * RD_K);
        st_nxt.nfull  = ucnt_new > UCNT_W'(UNITS - 2 * WR_K);
        st_nxt.wcnt   = CNT_W'(ucnt_new / UCNT_W'(RD_K));
        // top bits of units over capacity, saturating when full
        if (ucnt_new[PTR_W]) begin
            st_nxt.frac = '1;
        end else begin
            st_nxt.frac = ucnt_new[PTR_W-1 -: PREC];
        end
        // output register stage, one extra cycle
        // in look-ahead mode the register is the fall-through stage itself, so data and
        // valid move together and a consumed word is never shown a second time
        st_nxt.oreg   = LOOK_AHEAD ? st_nxt.dout : st_r.dout;
        st_nxt.ovalid = LOOK_AHEAD ? st_nxt.dvalid : st_r.dvalid;
        if (srst) begin
            st_nxt = '0;
            st_nxt.empty  = 1'b1;
            st_nxt.nempty = 1'b1;
            st_nxt.dead   = TMR_W'(cfq_pkg::DISABLE_CYCLES);
        end
    end

    // state register, queue starts empty and disabled
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_r        <= '0;
            st_r.empty  <= 1'b1;
            st_r.nempty <= 1'b1;
            st_r.dead   <= TMR_W'(cfq_pkg::DISABLE_CYCLES);
        end else begin
            st_r <= st_nxt;
        end
    end

    // storage write, no reset needed for contents
    always_ff @(posedge CORE_CLK) begin
        if (!srst && st_nxt.wptr != st_r.wptr) begin
            for (int i = 0; i < WR_K; i++) begin
                mem[PTR_W'(st_r.wptr + PTR_W'(i))] <= Q.write_data[i*UNIT_W +: UNIT_W];
            end
        end
    end

    // ******************************************************************
    // outputs
    // ******************************************************************
    assign Q.read_data       = OUT_REG ? st_r.oreg : st_r.dout;
    assign Q.read_valid      = OUT_REG ? st_r.ovalid : st_r.dvalid;
    assign Q.full            = st_r.full;
    assign Q.empty           = st_r.empty;
    assign Q.near_empty_flag = st_r.nempty;
    assign Q.near_full_flag  = st_r.nfull;
    assign Q.word_count      = st_r.wcnt;
    assign Q.fill_fraction   = st_r.frac;
    assign Q.rst_busy        = (st_r.dead != '0);
endmodule

// ==== rtl/cfq_ctrl.sv ====
`timescale 1ns/10ps
module cfq_ctrl #(
    parameter int WR_W  = cfq_pkg::DEF_WR_WIDTH,
    parameter int RD_W  = cfq_pkg::DEF_RD_WIDTH,
    parameter int CNT_W = 5,
    parameter int PREC  = cfq_pkg::DEF_PRECISION
) (
    input  wire logic                          CORE_CLK,
    input  wire logic                          ARST_N,
    input  wire logic [cfq_pkg::CTRL_ADDR_W-1:0] ADDR,
    input  wire logic [31:0]                   WDATA,
    input  wire logic                          WR,
    input  wire logic                          RD,
    output logic      [31:0]                   RDATA,
    cfq_if.ctl                                 Q
);
    localparam int HW = cfq_pkg::RST_HOLD_PREF;
    localparam int WT = cfq_pkg::POST_RST_WAIT;
    localparam int TW = 6;

    // ******************************************************************
    // controller state
    // ******************************************************************
    typedef struct packed {
        logic [TW-1:0]   hold;    // reset hold countdown
        logic [TW-1:0]   wait_c;  // no-access countdown
        logic            wstb;
        logic [WR_W-1:0] wdat;
        logic            rstb;
        logic [31:0]     rdata;
        logic [31:0]     last;    // last word returned
    } cfq_c_state_type;
    cfq_c_state_type st_r;
    cfq_c_state_type st_nxt;

    always_comb begin
        logic quiet;
        quiet  = 1'b0;
        st_nxt = st_r;
        st_nxt.wstb  = 1'b0;
        st_nxt.rstb  = 1'b0;
        st_nxt.rdata = '0;
        if (st_r.hold != '0) st_nxt.hold = st_r.hold - TW'(1);
        if (st_r.hold == TW'(1)) st_nxt.wait_c = TW'(WT);
        else if (st_r.wait_c != '0) st_nxt.wait_c = st_r.wait_c - TW'(1);
        // strobes only outside reset, wait window and busy
        quiet = (st_r.hold == '0) && (st_r.wait_c == '0) && !Q.rst_busy;
        if (Q.read_valid) st_nxt.last = 32'(Q.read_data);
        if (WR && ADDR == cfq_pkg::REG_CTRL && WDATA[cfq_pkg::CTRL_SRST_BIT])
            st_nxt.hold = TW'(HW);
        // full and empty are left to the queue, which refuses on its own
        if (WR && ADDR == cfq_pkg::REG_WDATA && quiet) begin
            st_nxt.wstb = 1'b1;
            st_nxt.wdat = WR_W'(WDATA);
        end
        if (WR && ADDR == cfq_pkg::REG_POP && quiet)
            st_nxt.rstb = 1'b1;
        if (RD) begin
            unique case (ADDR)
                cfq_pkg::REG_RDATA:  st_nxt.rdata = st_r.last;
                cfq_pkg::REG_STATUS: st_nxt.rdata = 32'({
                    Q.read_valid, !quiet, Q.near_full_flag,
                    Q.near_empty_flag, Q.full, Q.empty});
                cfq_pkg::REG_COUNT:  st_nxt.rdata = 32'({Q.fill_fraction, 16'h0})
                                                    | 32'(Q.word_count);
                default:             st_nxt.rdata = '0;
            endcase
        end
    end

    // start with initial wait so queue settles
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_r        <= '0;
            st_r.wait_c <= TW'(cfq_pkg::NORST_WAIT_CYCLES);
        end else begin
            st_r <= st_nxt;
        end
    end

    assign Q.rst_req      = (st_r.hold != '0);
    assign Q.enable       = 1'b1;
    assign Q.write_strobe = st_r.wstb;
    assign Q.write_data   = st_r.wdat;
    assign Q.read_strobe  = st_r.rstb;
    assign RDATA          = st_r.rdata;
endmodule

// ==== sim/cfq_checker.sv ====
`timescale 1ns/10ps
// ****************************************
// queue interface checker
// ****************************************
module cfq_checker #(
    parameter int DEPTH = 16,
    parameter int CNT_W = 5,
    parameter int PREC  = 4
) (
    input wire logic             CORE_CLK,
    input wire logic             ARST_N,
    input wire logic             rst_req,
    input wire logic             enable,
    input wire logic             write_strobe,
    input wire logic             read_strobe,
    input wire logic             read_valid,
    input wire logic             full,
    input wire logic             empty,
    input wire logic             near_empty_flag,
    input wire logic             near_full_flag,
    input wire logic [CNT_W-1:0] word_count,
    input wire logic [PREC-1:0]  fill_fraction,
    input wire logic             rst_busy
);
    logic [5:0]      gap_r;     // cycles since the reset request last stood high
    logic            soft_r;    // a soft reset has been seen since power-up
    logic [PREC-1:0] frac_exp;  // expected fill fraction, saturating when full
    logic            wr_take;   // a write the queue must accept
    logic            rd_take;   // a read the queue must accept

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);

    // gap counter saturates so a long idle spell never wraps back under the limit
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            gap_r  <= 6'h00;
            soft_r <= 1'b0;
        end else begin
            soft_r <= soft_r | rst_req;
            gap_r  <= rst_req ? 6'h00 : ((gap_r == 6'h3f) ? gap_r : gap_r + 6'h01);
        end
    end

    // reference values worked out from the count, the flags and the strobes
    always_comb begin
        frac_exp = full ? '1 : PREC'((int'(word_count) << PREC) / DEPTH);
        wr_take  = write_strobe && !full && !rst_busy && enable;
        rd_take  = read_strobe && !empty && !rst_busy && enable;
    end

    chk_empty_match: assert property (empty == (word_count == '0))
        else $error("empty flag disagrees with count");
    chk_full_match: assert property (full == (int'(word_count) == DEPTH))
        else $error("full flag disagrees with count");
    chk_near_flags: assert property ((near_empty_flag == (word_count <= 1))
        && (near_full_flag == (int'(word_count) >= DEPTH - 1)))
        else $error("near flags disagree with count");
    chk_fill_frac: assert property (fill_fraction == frac_exp)
        else $error("fill fraction wrong");
    chk_write_stores: assert property (wr_take && !read_strobe |=>
        word_count == $past(word_count) + CNT_W'(1))
        else $error("accepted write did not raise count");
    chk_full_refuse: assert property (full && write_strobe && !read_strobe |=>
        $stable(word_count) && full)
        else $error("write while full changed queue");
    chk_empty_refuse: assert property (empty && read_strobe && !write_strobe |=>
        $stable(word_count) && !read_valid)
        else $error("read while empty changed queue");
    chk_read_answer: assert property (rd_take |=> read_valid)
        else $error("accepted read gave no data");
    chk_valid_cause: assert property (read_valid |-> $past(rd_take))
        else $error("read valid without a read one cycle before");
    chk_soft_hold: assert property ($rose(rst_req) |-> rst_req [*5])
        else $error("soft reset shorter than five cycles");
    chk_access_gap: assert property ((write_strobe || read_strobe) |->
        !rst_req && !rst_busy && (gap_r >= (soft_r ? 6'd30 : 6'd8)))
        else $error("strobe inside the no access zone");

    // main scenarios reached
    cov_full: cover property (full && write_strobe);
    cov_empty_read: cover property (empty && read_strobe);
    cov_soft_reset: cover property ($fell(rst_req));
    cov_read: cover property (read_valid);
endmodule

// ==== sim/cfq_tb_top.sv ====
`timescale 1ns/10ps
module cfq_tb_top;
    typedef struct {bit pop; logic [31:0] val; int cnt;} cfq_row_type;
    logic        core_clk = 1'b0;
    logic        arst_n   = 1'b0;
    logic [3:0]  addr     = 4'h0;
    logic [31:0] wdata    = 32'h0000_0000;
    logic        wr       = 1'b0;
    logic        rd       = 1'b0;
    logic [31:0] rdata;
    logic [31:0] got;
    int          n_fail    = 0;
    int          tests_run = 0;
    int          cyc       = 0;
    // ordinary traffic: push or pop, word pushed or expected, count after
    cfq_row_type rows [6] = '{'{1'b0, 32'h0000_00a5, 1}, '{1'b0, 32'h0000_005a, 2},
        '{1'b1, 32'h0000_00a5, 1}, '{1'b0, 32'h0000_0c3c, 2},
        '{1'b1, 32'h0000_005a, 1}, '{1'b1, 32'h0000_0c3c, 0}};

    cfq_if #(.WR_W(32), .RD_W(32), .CNT_W(5), .PREC(4)) bus ();
    cfq_queue #(.DEPTH(16)) u_cfq_queue (.CORE_CLK(core_clk), .ARST_N(arst_n), .Q(bus));
    cfq_ctrl u_cfq_ctrl (.CORE_CLK(core_clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .Q(bus));
    cfq_checker u_cfq_checker (.CORE_CLK(core_clk), .ARST_N(arst_n), .rst_req(bus.rst_req),
        .enable(bus.enable), .write_strobe(bus.write_strobe), .read_strobe(bus.read_strobe),
        .read_valid(bus.read_valid), .full(bus.full), .empty(bus.empty),
        .near_empty_flag(bus.near_empty_flag), .near_full_flag(bus.near_full_flag),
        .word_count(bus.word_count), .fill_fraction(bus.fill_fraction),
        .rst_busy(bus.rst_busy));

    // second queue in look-ahead mode with output register, strobed straight by the bench
    cfq_if #(.WR_W(32), .RD_W(32), .CNT_W(5), .PREC(4)) la_bus ();
    cfq_queue #(.DEPTH(16), .LOOK_AHEAD(1'b1), .OUT_REG(1'b1)) u_cfq_queue_la (
        .CORE_CLK(core_clk), .ARST_N(arst_n), .Q(la_bus));

    always #20 core_clk = ~core_clk;

    // watchdog: the whole run needs only a few hundred cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // write cycle, then two idle edges so the queue has taken the strobe
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic pop(output logic [31:0] d);
        reg_wr(cfq_pkg::REG_POP, 32'h0000_0000);
        reg_rd(cfq_pkg::REG_RDATA, d);
    endtask

    // flags, count and fraction for n stored words of a 16 deep queue
    task automatic check_state(input int n);
        logic [31:0] s;
        reg_rd(cfq_pkg::REG_STATUS, s);
        check("flags", {28'h0, s[3:0]}, {28'h0, n >= 15, n <= 1, n == 16, n == 0});
        reg_rd(cfq_pkg::REG_COUNT, s);
        check("count", {27'h0, s[4:0]}, 32'(n));
        check("fraction", {28'h0, s[19:16]}, (n == 16) ? 32'h0000_000f : 32'(n));
    endtask

    // soft or power-up reset: let the request land, wait out busy, then the quiet zone
    task automatic wait_ready();
        logic [31:0] s;
        repeat (8) @(posedge core_clk);
        for (int i = 0; i < 100; i++) begin
            reg_rd(cfq_pkg::REG_STATUS, s);
            if (s[cfq_pkg::ST_BUSY] === 1'b0) begin
                break;
            end
        end
        repeat (32) @(posedge core_clk);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        la_bus.rst_req      <= 1'b0;
        la_bus.enable       <= 1'b1;
        la_bus.write_strobe <= 1'b0;
        la_bus.write_data   <= 32'h0000_0000;
        la_bus.read_strobe  <= 1'b0;
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        // a write inside the dead window after reset must be ignored
        la_bus.write_strobe <= 1'b1;
        repeat (2) @(posedge core_clk);
        la_bus.write_strobe <= 1'b0;
        check_state(0);
        reg_wr(cfq_pkg::REG_CTRL, 32'h0000_0001);
        wait_ready();
        foreach (rows[i]) begin
            if (rows[i].pop) begin
                pop(got);
                check("row word", got, rows[i].val);
            end else begin
                reg_wr(cfq_pkg::REG_WDATA, rows[i].val);
            end
            check_state(rows[i].cnt);
        end
        // fill to the brim, then one write too many
        for (int i = 0; i < 16; i++) begin
            reg_wr(cfq_pkg::REG_WDATA, 32'h0000_0100 + 32'(i));
            check_state(i + 1);
        end
        reg_wr(cfq_pkg::REG_WDATA, 32'hdead_beef);
        check_state(16);
        // drain in order, then one read too many
        for (int i = 0; i < 16; i++) begin
            pop(got);
            check("drain word", got, 32'h0000_0100 + 32'(i));
            check_state(15 - i);
        end
        pop(got);
        check("last word kept", got, 32'h0000_010f);
        check_state(0);
        // soft reset with words stored flushes the queue
        for (int i = 0; i < 3; i++) begin
            reg_wr(cfq_pkg::REG_WDATA, 32'h0000_0200 + 32'(i));
        end
        reg_wr(cfq_pkg::REG_CTRL, 32'h0000_0003);
        wait_ready();
        check_state(0);
        reg_wr(cfq_pkg::REG_WDATA, 32'h0000_0055);
        pop(got);
        check("after soft reset", got, 32'h0000_0055);
        // look-ahead: the oldest word shows without a strobe, a strobe consumes it
        check("la busy refused", {27'h0, la_bus.word_count}, 32'h0000_0000);
        @(posedge core_clk);
        la_bus.write_data   <= 32'h0000_0a11;
        la_bus.write_strobe <= 1'b1;
        @(posedge core_clk);
        la_bus.write_data   <= 32'h0000_0a22;
        @(posedge core_clk);
        la_bus.write_strobe <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        check("la valid", {31'h0, la_bus.read_valid}, 32'h0000_0001);
        check("la head", la_bus.read_data, 32'h0000_0a11);
        for (int i = 0; i < 2; i++) begin
            la_bus.read_strobe <= 1'b1;
            @(posedge core_clk);
            la_bus.read_strobe <= 1'b0;
            @(posedge core_clk);
            #1;
            check("la valid after strobe", {31'h0, la_bus.read_valid}, 32'(i == 0));
            if (i == 0) begin
                check("la second word", la_bus.read_data, 32'h0000_0a22);
            end
        end
        check("la drained", {31'h0, la_bus.empty}, 32'h0000_0001);
        summarize();
    end
endmodule
